/* File: rtl/dsra_pkg.sv */
// Package for the dual serial register access block.
// Assumes one core clock that oversamples both serial links.
package dsra_pkg;
  localparam int FRAME_BITS    = 32;
  localparam int ADDR_BITS     = 6;
  localparam int DATA_BITS     = 24;
  localparam int REG_COUNT     = 64;
  localparam int RW_POS        = 31;
  localparam int ADDR_MSB      = 30;
  localparam int ADDR_LSB      = 25;
  localparam int DATA_MSB      = 23;
  localparam logic [5:0] CNT_ADDR_DONE = 6'h07;
  localparam logic [5:0] CNT_FRAME_END = 6'h20;
  localparam logic [5:0] CNT_RESET     = 6'h00;
  localparam logic [23:0] REG_RESET    = 24'h0000_00;
  localparam logic [23:0] IRQ_BIT_MASK = 24'h0000_01;
  localparam int IRQ_A_INDEX   = 0;
  localparam int IRQ_B_INDEX   = 3;
endpackage : dsra_pkg

/* File: rtl/dsra_port.sv */
// One serial port engine, oversampling the host clock and select.
// Assumes core clock well above four times the serial clock.
`timescale 1ns/1ps
module dsra_port (
  // Core
  input  wire logic     clk_in,
  input  wire logic     rst_n_in,
  input  wire logic     ce_in,
  // Pins
  input  wire logic     sclk_in,
  input  wire logic     sel_in,
  input  wire logic     sdi_in,
  output logic          sdo_out,
  output logic          sdo_oe_out,
  // Register side
  dsra_port_if.engine   rf
);
  logic [2:0]  sclk_sync_reg;
  logic [1:0]  sel_sync_reg;
  logic [1:0]  sdi_sync_reg;
  logic [5:0]  cnt_reg;
  logic [31:0] shift_reg;
  logic [23:0] tx_reg;
  logic        wr_reg;
  logic        sdo_reg;
  wire         rise_w   = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  wire         fall_w   = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  wire         active_w = sel_sync_reg[1];
  wire [31:0]  shift_next = {shift_reg[30:0], sdi_sync_reg[1]};
  wire         addr_done_w = rise_w && (cnt_reg == 6'(dsra_pkg::CNT_ADDR_DONE - 6'h01));
  wire         commit_w = fall_w && active_w && (cnt_reg == dsra_pkg::CNT_FRAME_END)
                          && shift_reg[dsra_pkg::RW_POS];

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sclk_sync_reg <= 3'h0;
      sel_sync_reg  <= 2'h0;
      sdi_sync_reg  <= 2'h0;
    end else if (ce_in) begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_in};
      sel_sync_reg  <= {sel_sync_reg[0], sel_in};
      sdi_sync_reg  <= {sdi_sync_reg[0], sdi_in};
    end
  end

  // Counter cleared while select low, so an aborted frame leaves nothing
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || (ce_in && !active_w)) begin
      cnt_reg   <= dsra_pkg::CNT_RESET;
      shift_reg <= 32'h0000_0000;
    end else if (ce_in && rise_w && cnt_reg != dsra_pkg::CNT_FRAME_END) begin
      cnt_reg   <= cnt_reg + 6'h01;
      shift_reg <= shift_next;
    end
  end

  // Read data shifted out MSB first on falling edges after the null bit
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tx_reg  <= dsra_pkg::REG_RESET;
      sdo_reg <= 1'b0;
    end else if (ce_in) begin
      if (!active_w) begin
        tx_reg  <= dsra_pkg::REG_RESET;
        sdo_reg <= 1'b0;
      end else if (fall_w && cnt_reg == dsra_pkg::CNT_ADDR_DONE + 6'h01) begin
        sdo_reg <= rf.rd_data[dsra_pkg::DATA_MSB];
        tx_reg  <= {rf.rd_data[22:0], 1'b0};
      end else if (fall_w && cnt_reg > dsra_pkg::CNT_ADDR_DONE + 6'h01
                   && cnt_reg < dsra_pkg::CNT_FRAME_END) begin
        sdo_reg <= tx_reg[23];
        tx_reg  <= {tx_reg[22:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_reg <= 1'b0;
    end else if (ce_in) begin
      wr_reg <= commit_w;
    end
  end

  logic [5:0] raddr_reg;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      raddr_reg <= 6'h00;
    end else if (ce_in && addr_done_w) begin
      raddr_reg <= shift_next[5:0];
    end
  end

  assign rf.rd_addr  = raddr_reg;
  assign rf.wr_valid = wr_reg;
  assign rf.wr_addr  = shift_reg[dsra_pkg::ADDR_MSB:dsra_pkg::ADDR_LSB];
  assign rf.wr_data  = shift_reg[dsra_pkg::DATA_MSB:0];
  assign sdo_out     = sdo_reg;
  assign sdo_oe_out  = active_w;

  property p_abort_clears;
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && !active_w) |=> cnt_reg == dsra_pkg::CNT_RESET;
  endproperty
  a_abort_clears: assert property (p_abort_clears)
    else $error("counter not cleared on deselect");

  // Enable trails the select pin by exactly the two sync stages
  property p_oe_follows_sel;
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in ##1 ce_in |=> sdo_oe_out == $past(sel_in, 2);
  endproperty
  a_oe_follows_sel: assert property (p_oe_follows_sel)
    else $error("data out enable does not follow select");

  property p_count_bound;
    @(posedge clk_in) disable iff (!rst_n_in)
    cnt_reg <= dsra_pkg::CNT_FRAME_END;
  endproperty
  a_count_bound: assert property (p_count_bound)
    else $error("bit count past frame");

  property p_rise_counts;
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && rise_w && active_w && cnt_reg < dsra_pkg::CNT_FRAME_END)
    |=> cnt_reg == $past(cnt_reg) + 6'h01;
  endproperty
  a_rise_counts: assert property (p_rise_counts)
    else $error("rising edge not counted");

  property p_write_only_rw;
    @(posedge clk_in) disable iff (!rst_n_in)
    rf.wr_valid |-> $past(shift_reg[dsra_pkg::RW_POS]);
  endproperty
  a_write_only_rw: assert property (p_write_only_rw)
    else $error("write without write bit");

  property p_commit_at_end;
    @(posedge clk_in) disable iff (!rst_n_in)
    rf.wr_valid |-> $past(cnt_reg) == dsra_pkg::CNT_FRAME_END;
  endproperty
  a_commit_at_end: assert property (p_commit_at_end)
    else $error("write before the last bit");
endmodule : dsra_port

/* File: rtl/dsra_port_if.sv */
// Bundle between a serial port engine and the shared register file.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
interface dsra_port_if;
  logic        wr_valid;
  logic [5:0]  wr_addr;
  logic [23:0] wr_data;
  logic [5:0]  rd_addr;
  logic [23:0] rd_data;
  modport engine (output wr_valid, output wr_addr, output wr_data,
                  output rd_addr, input rd_data);
  modport regs   (input wr_valid, input wr_addr, input wr_data,
                  input rd_addr, output rd_data);
endinterface : dsra_port_if

/* File: rtl/dsra_top.sv */
// Dual serial port access to one shared 64 x 24 register set.
// Assumes hosts keep select, clock and data timing as the link asks.
//
// Operation
// - Two independent ports share one register set
// - Bits shift in on rising serial clock edge, out on falling
// - Select active high; clock ignored when low
// - Frame: write bit, 6 address, null, 24 data
// - Six address bits select one of 64
// - Write data on input, read data on output
// - Each port has its own interrupt output
// - First bit one writes, zero reads only
// - MSB first; commit on 32nd falling edge
// - Early deselect discards the whole transfer
// - Data output released while select low
`timescale 1ns/1ps
module dsra_top (
  // Core
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        clk_en_in,
  // Port A
  input  wire logic        port_a_serial_clock_in,
  input  wire logic        port_a_select_in,
  input  wire logic        port_a_data_in_in,
  output logic             port_a_data_out_out,
  output logic             port_a_data_out_oe_out,
  output logic             port_a_irq_out,
  // Port B
  input  wire logic        port_b_serial_clock_in,
  input  wire logic        port_b_select_in,
  input  wire logic        port_b_data_in_in,
  output logic             port_b_data_out_out,
  output logic             port_b_data_out_oe_out,
  output logic             port_b_irq_out
);
  logic [23:0] regs_reg [dsra_pkg::REG_COUNT];
  logic        irq_a_reg;
  logic        irq_b_reg;

  dsra_port_if a_if ();
  dsra_port_if b_if ();

  dsra_port u_port_a (
    .clk_in     (ref_clk_in),
    .rst_n_in   (reset_n_in),
    .ce_in      (clk_en_in),
    .sclk_in    (port_a_serial_clock_in),
    .sel_in     (port_a_select_in),
    .sdi_in     (port_a_data_in_in),
    .sdo_out    (port_a_data_out_out),
    .sdo_oe_out (port_a_data_out_oe_out),
    .rf         (a_if.engine)
  );
  dsra_port u_port_b (
    .clk_in     (ref_clk_in),
    .rst_n_in   (reset_n_in),
    .ce_in      (clk_en_in),
    .sclk_in    (port_b_serial_clock_in),
    .sel_in     (port_b_select_in),
    .sdi_in     (port_b_data_in_in),
    .sdo_out    (port_b_data_out_out),
    .sdo_oe_out (port_b_data_out_oe_out),
    .rf         (b_if.engine)
  );

  // Same address space for both ports
  assign a_if.rd_data = regs_reg[a_if.rd_addr];
  assign b_if.rd_data = regs_reg[b_if.rd_addr];

  // Port A applied first, port B second: B wins an address clash whole
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < dsra_pkg::REG_COUNT; i++) begin
        regs_reg[i] <= dsra_pkg::REG_RESET;
      end
    end else if (clk_en_in) begin
      if (a_if.wr_valid) begin
        regs_reg[a_if.wr_addr] <= a_if.wr_data;
      end
      if (b_if.wr_valid) begin
        regs_reg[b_if.wr_addr] <= b_if.wr_data;
      end
    end
  end

  // One mask decode shared by both interrupt lines
  function automatic logic irq_level(input logic [23:0] word);
    return |(word & dsra_pkg::IRQ_BIT_MASK);
  endfunction : irq_level

  wire irq_a_next = irq_level(regs_reg[dsra_pkg::IRQ_A_INDEX]);
  wire irq_b_next = irq_level(regs_reg[dsra_pkg::IRQ_B_INDEX]);

  // Interrupt lines driven from low bit of a per-port register
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      irq_a_reg <= 1'b0;
      irq_b_reg <= 1'b0;
    end else if (clk_en_in) begin
      irq_a_reg <= irq_a_next;
      irq_b_reg <= irq_b_next;
    end
  end
  assign port_a_irq_out = irq_a_reg;
  assign port_b_irq_out = irq_b_reg;

  property p_b_wins_clash;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (clk_en_in && a_if.wr_valid && b_if.wr_valid && a_if.wr_addr == b_if.wr_addr)
    |=> regs_reg[$past(b_if.wr_addr)] == $past(b_if.wr_data);
  endproperty
  a_b_wins_clash: assert property (p_b_wins_clash)
    else $error("clash not resolved in fixed order");
  property p_a_commits;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (clk_en_in && a_if.wr_valid && !(b_if.wr_valid && b_if.wr_addr == a_if.wr_addr))
    |=> regs_reg[$past(a_if.wr_addr)] == $past(a_if.wr_data);
  endproperty
  a_a_commits: assert property (p_a_commits)
    else $error("port a write lost");
  property p_irq_a;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    clk_en_in |=> port_a_irq_out == $past(regs_reg[dsra_pkg::IRQ_A_INDEX][0]);
  endproperty
  a_irq_a: assert property (p_irq_a)
    else $error("port a irq wrong");

  property p_irq_b;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    clk_en_in |=> port_b_irq_out == $past(regs_reg[dsra_pkg::IRQ_B_INDEX][0]);
  endproperty
  a_irq_b: assert property (p_irq_b)
    else $error("port b irq wrong");

  property p_b_commits;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (clk_en_in && b_if.wr_valid)
    |=> regs_reg[$past(b_if.wr_addr)] == $past(b_if.wr_data);
  endproperty
  a_b_commits: assert property (p_b_commits)
    else $error("port b write lost");

  // Reads and frozen cycles must leave the addressed register alone
  property p_hold_a;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (!clk_en_in || (!a_if.wr_valid && !b_if.wr_valid))
    |=> regs_reg[$past(a_if.rd_addr)] == $past(regs_reg[a_if.rd_addr]);
  endproperty
  a_hold_a: assert property (p_hold_a)
    else $error("port a register changed without a write");

  property p_hold_b;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (!clk_en_in || (!a_if.wr_valid && !b_if.wr_valid))
    |=> regs_reg[$past(b_if.rd_addr)] == $past(regs_reg[b_if.rd_addr]);
  endproperty
  a_hold_b: assert property (p_hold_b)
    else $error("port b register changed without a write");

  property p_a_wr_sel;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    a_if.wr_valid |-> $past(port_a_data_out_oe_out);
  endproperty
  a_a_wr_sel: assert property (p_a_wr_sel)
    else $error("port a write without select");

  property p_b_wr_sel;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    b_if.wr_valid |-> $past(port_b_data_out_oe_out);
  endproperty
  a_b_wr_sel: assert property (p_b_wr_sel)
    else $error("port b write without select");

  // Reset is synchronous, so the clear shows one edge later
  property p_reset_clears;
    @(posedge ref_clk_in)
    !reset_n_in |=> !port_a_irq_out && !port_b_irq_out
                    && regs_reg[a_if.rd_addr] == dsra_pkg::REG_RESET;
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("reset did not clear state");
  c_a_write: cover property (@(posedge ref_clk_in) a_if.wr_valid);
  c_b_write: cover property (@(posedge ref_clk_in) b_if.wr_valid);
  c_both: cover property (@(posedge ref_clk_in) a_if.wr_valid && b_if.wr_valid);
  c_clash: cover property (@(posedge ref_clk_in)
    a_if.wr_valid && b_if.wr_valid && a_if.wr_addr == b_if.wr_addr);
  c_irq_both: cover property (@(posedge ref_clk_in) port_a_irq_out && port_b_irq_out);
endmodule : dsra_top

/* File: tb/dsra_host.sv */
// Host model for one serial port of the dual register access block.
// Assumes an 80 ns link clock, unrelated to the core clock.
`timescale 1ns/1ps
module dsra_host (
  // Pins towards the device
  output logic      sclk_out,
  output logic      sel_out,
  output logic      sdi_out,
  input  wire logic sdo_in
);
  initial begin
    sclk_out = 1'b0;
    sel_out  = 1'b0;
    sdi_out  = 1'b0;
  end

  // Frame of n bits; n below 32 aborts early
  task automatic xfer(input logic [31:0] word, input int n, output logic [23:0] rd);
    rd      = 24'h00_0000;
    sel_out = 1'b1;
    #40;
    for (int i = 0; i < n; i++) begin
      sdi_out = word[31 - i];
      #40 sclk_out = 1'b1;
      if (i >= 8) rd = {rd[22:0], sdo_in};
      #40 sclk_out = 1'b0;
    end
    #40 sel_out = 1'b0;
    // Released line must not look like held data
    sdi_out = ~sdi_out;
    #80;
  endtask : xfer
endmodule : dsra_host

/* File: tb/test_dual_spi_register_access.sv */
// Testbench for the dual serial register access block.
// Assumes two host models driving the ports; core clock 250 MHz.
`timescale 1ns/1ps
module test_dual_spi_register_access;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic clk_en_in  = 1'b1;
  logic a_sclk, a_sel, a_sdi, a_sdo, a_oe, a_irq;
  logic b_sclk, b_sel, b_sdi, b_sdo, b_oe, b_irq;
  int   errors      = 0;
  int   comparisons = 0;

  always #2 ref_clk_in = ~ref_clk_in;

  dsra_top u_dsra_top (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
    .port_a_serial_clock_in(a_sclk), .port_a_select_in(a_sel), .port_a_data_in_in(a_sdi),
    .port_a_data_out_out(a_sdo), .port_a_data_out_oe_out(a_oe), .port_a_irq_out(a_irq),
    .port_b_serial_clock_in(b_sclk), .port_b_select_in(b_sel), .port_b_data_in_in(b_sdi),
    .port_b_data_out_out(b_sdo), .port_b_data_out_oe_out(b_oe), .port_b_irq_out(b_irq));
  // Released data line shows the inverse, so a sample outside select reads wrong
  dsra_host u_host_a (.sclk_out(a_sclk), .sel_out(a_sel), .sdi_out(a_sdi),
                      .sdo_in(a_oe ? a_sdo : ~a_sdo));
  dsra_host u_host_b (.sclk_out(b_sclk), .sel_out(b_sel), .sdi_out(b_sdi),
                      .sdo_in(b_oe ? b_sdo : ~b_sdo));

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input bit pb, input logic rw, input logic [5:0] ad,
                      input logic [23:0] d, input int n, output logic [23:0] rd);
    if (pb) u_host_b.xfer({rw, ad, 1'b0, d}, n, rd);
    else u_host_a.xfer({rw, ad, 1'b0, d}, n, rd);
  endtask : xfer

  // Read sends all-ones data bits, which must be ignored
  task automatic expect_reg(input bit pb, input logic [5:0] ad, input logic [23:0] exp);
    logic [23:0] r;
    xfer(pb, 1'b0, ad, 24'hFF_FFFF, 32, r);
    check(r, exp);
  endtask : expect_reg

  task automatic wr(input bit pb, input logic [5:0] ad, input logic [23:0] d);
    logic [23:0] r;
    xfer(pb, 1'b1, ad, d, 32, r);
  endtask : wr

  task automatic test_reset;
    check(24'({a_sdo, a_oe, a_irq, b_sdo, b_oe, b_irq}), 24'h00_0000);
    expect_reg(1'b0, 6'h3F, 24'h00_0000);
    expect_reg(1'b1, 6'h00, 24'h00_0000);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_shared;
    wr(1'b0, 6'h3F, 24'hA5_C3F0);
    wr(1'b1, 6'h01, 24'h5A_0F0F);
    expect_reg(1'b1, 6'h3F, 24'hA5_C3F0);
    expect_reg(1'b0, 6'h01, 24'h5A_0F0F);
    expect_reg(1'b0, 6'h3E, 24'h00_0000);
    check(24'({a_oe, b_oe}), 24'h00_0000);
    $display("test_shared done");
  endtask : test_shared

  task automatic test_abort;
    logic [23:0] r;
    xfer(1'b0, 1'b1, 6'h3F, 24'h12_3456, 31, r);
    expect_reg(1'b1, 6'h3F, 24'hA5_C3F0);
    xfer(1'b1, 1'b0, 6'h3F, 24'h00_0000, 32, r);
    check(r, 24'hA5_C3F0);
    expect_reg(1'b0, 6'h3F, 24'hA5_C3F0);
    $display("test_abort done");
  endtask : test_abort

  task automatic test_irq;
    wr(1'b0, 6'h00, 24'h00_0001);
    check(24'({a_irq, b_irq}), 24'h00_0002);
    wr(1'b1, 6'h03, 24'h00_0001);
    check(24'({a_irq, b_irq}), 24'h00_0003);
    wr(1'b1, 6'h00, 24'h00_0000);
    check(24'({a_irq, b_irq}), 24'h00_0001);
    wr(1'b0, 6'h03, 24'h00_0000);
    check(24'({a_irq, b_irq}), 24'h00_0000);
    $display("test_irq done");
  endtask : test_irq

  // Same-cycle commits to one register; port B is applied last
  task automatic test_concurrent;
    fork
      wr(1'b0, 6'h15, 24'h11_1111);
      wr(1'b1, 6'h15, 24'h22_2222);
      #200 check(24'({a_oe, b_oe}), 24'h00_0003);
    join
    fork
      expect_reg(1'b0, 6'h15, 24'h22_2222);
      expect_reg(1'b1, 6'h01, 24'h5A_0F0F);
    join
    $display("test_concurrent done");
  endtask : test_concurrent

  // A frame sent while the core is frozen must leave no trace
  task automatic test_freeze;
    clk_en_in = 1'b0;
    wr(1'b0, 6'h3F, 24'h0F_0F0F);
    @(negedge ref_clk_in) clk_en_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    expect_reg(1'b0, 6'h3F, 24'hA5_C3F0);
    $display("test_freeze done");
  endtask : test_freeze

  // Mid-run reset must clear every register and both interrupt lines
  task automatic test_midreset;
    wr(1'b0, 6'h00, 24'h00_0001);
    check(24'(a_irq), 24'h00_0001);
    @(negedge ref_clk_in) reset_n_in = 1'b0;
    repeat (8) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    check(24'({a_irq, b_irq, a_oe, b_oe}), 24'h00_0000);
    expect_reg(1'b1, 6'h3F, 24'h00_0000);
    expect_reg(1'b0, 6'h15, 24'h00_0000);
    $display("test_midreset done");
  endtask : test_midreset

  task automatic summarize;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  initial begin
    repeat (8) @(posedge ref_clk_in);
    @(negedge ref_clk_in) reset_n_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    test_reset();
    test_shared();
    test_abort();
    test_irq();
    test_concurrent();
    test_freeze();
    test_midreset();
    summarize();
  end

  // About 22 frames of 2.72 us each; generous margin
  initial begin
    #300_000;
    errors++;
    summarize();
  end
endmodule : test_dual_spi_register_access
